// ===== bench/sto_drive_model.sv
// Drive stage model: reports its shut-off state on the feedback pair.
// Assumes the shut-off contacts arrive synchronous to pclk.
`timescale 1ns/1ps
module sto_drive_model #(
	parameter int LAT = 3
) (
	// Clock and reset.
	input logic pclk,
	input logic presetn,
	// Shut-off contacts in, feedback contacts out.
	input logic off_1,
	input logic off_2,
	output logic fb,
	output logic fb_ret
);
	logic [LAT-1:0] pipe_r;
	// The power stage settles late and needs both contacts closed.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) pipe_r <= '0;
		else pipe_r <= {pipe_r[LAT-2:0], off_1 & off_2};
	end
	// Closed feedback means driving, open means shut off.
	assign fb = pipe_r[LAT-1];
	assign fb_ret = pipe_r[LAT-1];
endmodule

// ===== bench/sto_properties.sv
// Concurrent checks on the ports of the safe torque off top module.
// Assumes the bench shrinks the filter and delay counts by parameter.
`timescale 1ns/1ps
module sto_checker #(
	parameter logic [sto_pkg::DEB_W-1:0] P_DEB_CYC = 18'h0_0004,
	parameter logic [sto_pkg::DW-1:0] P_DLY1 = 33'h0_0000_0014
) (
	// Clock, reset and bus handshake.
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pready,
	input logic pslverr,
	// Axis A pins.
	input logic axis_a_switch_in_1,
	input logic axis_a_switch_in_2,
	input logic axis_a_release_in,
	input logic axis_a_drive_feedback,
	input logic axis_a_drive_feedback_ret,
	input logic axis_a_shutoff_out_1,
	input logic axis_a_shutoff_out_2,
	input logic axis_a_monitor_out_1,
	input logic axis_a_monitor_out_2,
	input logic axis_a_feedback_monitor,
	// Axis B pins.
	input logic axis_b_switch_in_1,
	input logic axis_b_switch_in_2,
	input logic axis_b_shutoff_out_1,
	input logic axis_b_shutoff_out_2,
	input logic axis_b_monitor_out_1,
	input logic axis_b_monitor_out_2,
	// Delay switches.
	input logic [sto_pkg::SW_W-1:0] delay_select_switch_1,
	input logic [sto_pkg::SW_W-1:0] delay_select_switch_2
);
	import sto_pkg::*;
	localparam int DEB = int'(P_DEB_CYC);
	localparam int HOLD = int'(P_DLY1);
	localparam int RESP_HI = DEB + 16;
	localparam int END_LO = DEB + HOLD;
	localparam int END_HI = DEB + HOLD + 16;
	// Decoded conditions shared by several properties.
	wire a_closed = axis_a_switch_in_1 & axis_a_switch_in_2;
	wire b_closed = axis_b_switch_in_1 & axis_b_switch_in_2;
	wire a_fb = axis_a_drive_feedback & axis_a_drive_feedback_ret;
	wire a_zero = delay_select_switch_1[2:0] == DC_0 &&
		delay_select_switch_2[2:0] == DC_0;
	wire a_one = delay_select_switch_1[2:0] == DC_1 &&
		delay_select_switch_2[2:0] == DC_1;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////
	chk_pair_mon_a:
	assert property (axis_a_shutoff_out_1 == axis_a_shutoff_out_2 &&
		axis_a_monitor_out_1 == axis_a_shutoff_out_1 &&
		axis_a_monitor_out_2 == axis_a_shutoff_out_1)
		else $error("axis a outputs disagree");
	chk_pair_mon_b:
	assert property (axis_b_shutoff_out_1 == axis_b_shutoff_out_2 &&
		axis_b_monitor_out_1 == axis_b_shutoff_out_1 &&
		axis_b_monitor_out_2 == axis_b_shutoff_out_1)
		else $error("axis b outputs disagree");
	chk_zero_resp_a:
	assert property ($fell(a_closed) && a_zero |->
		##[1:RESP_HI] !axis_a_shutoff_out_1)
		else $error("zero delay shut-off too slow");
	chk_delay_hold_a:
	assert property ($fell(a_closed) && a_one && axis_a_shutoff_out_1 |->
		##HOLD axis_a_shutoff_out_1)
		else $error("shut-off came before the delay");
	chk_delay_end_a:
	assert property ($fell(a_closed) && a_one && axis_a_shutoff_out_1 |->
		##[END_LO:END_HI] !axis_a_shutoff_out_1)
		else $error("shut-off late after the delay");
	chk_release_edge_a:
	assert property ($rose(axis_a_shutoff_out_1) |->
		!$past(axis_a_release_in) && !$past(axis_a_release_in, DEB) &&
		$past(a_closed))
		else $error("axis a released without a release edge");
	chk_fb_off_a:
	assert property ((!a_fb)[*8] ##1 (!a_fb)[*4] |-> !axis_a_feedback_monitor)
		else $error("feedback monitor stuck closed");
	chk_fb_on_a:
	assert property (a_fb[*8] ##1 a_fb[*4] |-> axis_a_feedback_monitor)
		else $error("feedback monitor stuck open");
	chk_axis_indep:
	assert property ($fell(a_closed) && b_closed && axis_b_shutoff_out_1 |=>
		axis_b_shutoff_out_1[*8])
		else $error("axis a demand disturbed axis b");
	chk_apb_ready:
	assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	chk_apb_idle:
	assert property (!psel |=> !pready && !pslverr)
		else $error("ready without a transfer");
endmodule

// ===== bench/tb_dual_axis_safe_torque_off_logic.sv
// Self-checking bench for the two-axis safe torque off unit.
// Assumes shortened filter and delay counts set through parameters.
`timescale 1ns/1ps
module tb_dual_axis_safe_torque_off_logic;
	import sto_pkg::*;
	localparam logic [DEB_W-1:0] DEB = 18'h0_0004;
	localparam logic [DW-1:0] D1 = 33'h0_0000_0014;
	localparam logic [DW-1:0] D2 = 33'h0_0000_0028;
	localparam logic [DW-1:0] D3 = 33'h0_0000_003c;
	localparam logic [DW-1:0] D4 = 33'h0_0000_0050;
	localparam logic [DW-1:0] D5 = 33'h0_0000_0064;
	logic [DW-1:0] dly_t [8] = '{DLY_ZERO, D1, D2, D3, D4, D5, DLY_ZERO,
		DLY_ZERO};
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, irq, e;
	logic [AW-1:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [1:0] sw1, sw2, rel, fb, fbr, out1, out2, mon1, mon2, fmon;
	logic [SW_W-1:0] sel1, sel2;
	int mismatches = 0;
	int num_checks = 0;
	int cyc = 0;
	// Unit under test with both axes on bench vectors.
	sto_top #(.P_DEB_CYC(DEB), .P_DLY1(D1), .P_DLY2(D2), .P_DLY3(D3),
		.P_DLY4(D4), .P_DLY5(D5)) uut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq),
		.axis_a_switch_in_1(sw1[0]), .axis_a_switch_in_2(sw2[0]),
		.axis_a_release_in(rel[0]), .axis_a_drive_feedback(fb[0]),
		.axis_a_drive_feedback_ret(fbr[0]), .axis_a_shutoff_out_1(out1[0]),
		.axis_a_shutoff_out_2(out2[0]), .axis_a_monitor_out_1(mon1[0]),
		.axis_a_monitor_out_2(mon2[0]), .axis_a_feedback_monitor(fmon[0]),
		.axis_b_switch_in_1(sw1[1]), .axis_b_switch_in_2(sw2[1]),
		.axis_b_release_in(rel[1]), .axis_b_drive_feedback(fb[1]),
		.axis_b_drive_feedback_ret(fbr[1]), .axis_b_shutoff_out_1(out1[1]),
		.axis_b_shutoff_out_2(out2[1]), .axis_b_monitor_out_1(mon1[1]),
		.axis_b_monitor_out_2(mon2[1]), .axis_b_feedback_monitor(fmon[1]),
		.delay_select_switch_1(sel1), .delay_select_switch_2(sel2));
	// One drive stage per axis answers on the feedback pair.
	for (genvar i = 0; i < 2; i++) begin : g_drv
		sto_drive_model drv (.pclk(pclk), .presetn(presetn),
			.off_1(out1[i]), .off_2(out2[i]), .fb(fb[i]), .fb_ret(fbr[i]));
	end
	// Clock and hang guard; the run needs under two thousand cycles.
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			finish_test();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic chk(input string nm, input logic [31:0] x,
		input logic [31:0] g);
		num_checks++;
		if (g !== x) begin
			$display("wrong value %s expected %h seen %h", nm, x, g);
			mismatches++;
		end
	endtask
	// One APB transfer; the request stands until pready is sampled high.
	task automatic apb(input logic w, input logic [AW-1:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No local limit: a slave that never answers is caught by the guard.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input string nm, input logic [AW-1:0] a,
		input logic [31:0] x);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, x, q);
	endtask
	// Press and let go of the release contact, then wait for driving.
	task automatic release_ax(input int ax);
		int n;
		rel[ax] <= 1'b1;
		tick(12);
		chk("held release", 32'h0, 32'(out1[ax]));
		rel[ax] <= 1'b0;
		n = 0;
		while (out1[ax] !== 1'b1 && n < 40) begin
			tick(1);
			n++;
		end
	endtask
	// Run an axis, demand shut-off on one input and time the opening.
	task automatic run_code(input int ax, input logic [2:0] c,
		input logic [DW-1:0] d);
		int n;
		logic other;
		sel1[ax*3 +: 3] <= c;
		sel2[ax*3 +: 3] <= c;
		if (out1[ax] !== 1'b1) release_ax(ax);
		chk("released", 32'h1, 32'(out1[ax]));
		tick(12);
		chk("fb monitor on", 32'h1, 32'(fmon[ax]));
		other = out1[1-ax];
		if (c[0]) sw1[ax] <= 1'b0;
		else sw2[ax] <= 1'b0;
		n = 0;
		while (out1[ax] !== 1'b0 && n < 400) begin
			tick(1);
			n++;
		end
		chk("open time", 32'h1, 32'(n >= d + DEB && n <= d + DEB + 12));
		chk("outs open", 32'h0, 32'({out2[ax], mon1[ax], mon2[ax]}));
		chk("other axis", 32'(other), 32'(out1[1-ax]));
		sw1[ax] <= 1'b1;
		sw2[ax] <= 1'b1;
		tick(14);
		chk("fb monitor off", 32'h0, 32'(fmon[ax]));
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Main sequence: registers, release, interrupts, every delay code.
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		sw1 = 2'h3;
		sw2 = 2'h3;
		rel = 2'h0;
		sel1 = 6'h00;
		sel2 = 6'h00;
		tick(12);
		presetn <= 1'b1;
		tick(12);
		rd("status reset", REG_STAT, 32'h0000_0043);
		apb(1'b1, REG_STAT, 32'hffff_ffff);
		rd("status ro", REG_STAT, 32'h0000_0043);
		rd("unmapped", 8'h10, RD_ZERO);
		chk("slverr", 32'h1, 32'(e));
		rd("mask reset", REG_MASK, RD_ZERO);
		apb(1'b1, REG_CTRL, 32'h0000_000c);
		rd("ctrl", REG_CTRL, 32'h0000_000c);
		apb(1'b1, REG_CTRL, 32'h0000_0000);
		apb(1'b1, REG_IRQ, 32'h0000_001f);
		sw1[0] <= 1'b0;
		release_ax(0);
		chk("release refused", 32'h0, 32'(out1[0]));
		sw1[0] <= 1'b1;
		tick(12);
		release_ax(0);
		chk("axis a on", 32'h1, 32'(out1[0]));
		chk("axis b off", 32'h0, 32'(out1[1]));
		release_ax(1);
		tick(20);
		rd("status run", REG_STAT, 32'h0000_0070);
		rd("events", REG_IRQ, 32'h0000_000c);
		chk("irq masked", 32'h0, 32'(irq));
		apb(1'b1, REG_MASK, 32'h0000_0004);
		tick(2);
		chk("irq on", 32'h1, 32'(irq));
		apb(1'b1, REG_IRQ, 32'h0000_0004);
		tick(2);
		chk("irq cleared", 32'h0, 32'(irq));
		rd("event left", REG_IRQ, 32'h0000_0008);
		apb(1'b1, REG_MASK, 32'h0000_0000);
		// Software shut-off runs the selected delay; soft release undoes it.
		sel1 <= 6'h02;
		sel2 <= 6'h02;
		apb(1'b1, REG_CTRL, 32'h0000_0004);
		rd("status delay", REG_STAT, 32'h0000_0074);
		tick(45);
		chk("forced off", 32'h0, 32'(out1[0]));
		chk("b kept on", 32'h1, 32'(out1[1]));
		apb(1'b1, REG_CTRL, 32'h0000_0001);
		apb(1'b1, REG_CTRL, 32'h0000_0000);
		tick(4);
		chk("soft release", 32'h1, 32'(out1[0]));
		for (int c = 0; c < 7; c++) run_code(0, 3'(c), dly_t[c]);
		for (int c = 0; c < 6; c++)
			run_code(1, 3'(c), (c == 3) ? DLY_ZERO : dly_t[c]);
		sel1 <= 6'h18;
		sel2 <= 6'h19;
		tick(12);
		rd("status fault", REG_STAT, 32'h0000_0083);
		apb(1'b0, REG_IRQ, 32'h0000_0000);
		chk("mismatch event", 32'h0000_0010, q & 32'h0000_0010);
		finish_test();
	end
endmodule
bind sto_top sto_checker #(.P_DEB_CYC(P_DEB_CYC), .P_DLY1(P_DLY1)) chk (.*);

// ===== hw/sto_axis.sv
// One axis of the safe torque off logic: shut-off state, delay, release.
// Assumes filtered inputs synchronous to pclk and a stable delay count.
`timescale 1ns/1ps
module sto_axis (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Filtered inputs and software shut-off request.
	input sto_pkg::sto_axin_t inp,
	input wire logic force_off,
	input wire logic [sto_pkg::DW-1:0] dly_cyc,
	// State and events.
	output sto_pkg::sto_axout_t outp
);
	import sto_pkg::*;

	sto_state_t st_r, st_nxt;
	logic [DW-1:0] cnt_r, cnt_nxt;
	logic rel_q_r;
	logic armed_r;
	logic demand;
	logic rel_fall;

	////////////////////////////////////////////////////////////////////////
	// Either opened switch contact demands shut-off.
	assign demand = ~inp.sw1 | ~inp.sw2 | force_off;
	// Release acts on connected-to-opened, and only after an arming press.
	assign rel_fall = armed_r & rel_q_r & ~inp.rel;

	// Next state; a started delay runs to shut-off even if demand clears.
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		unique case (st_r)
			ST_SHUT: begin
				if (rel_fall && !demand) begin
					st_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				if (demand) begin
					if (dly_cyc == DLY_ZERO) begin
						st_nxt = ST_SHUT;
					end else begin
						st_nxt = ST_DELAY;
						cnt_nxt = dly_cyc - DW'(1);
					end
				end
			end
			ST_DELAY: begin
				if (cnt_r == DLY_ZERO) begin
					st_nxt = ST_SHUT;
				end else begin
					cnt_nxt = cnt_r - DW'(1);
				end
			end
		endcase
	end

	// Power-up lands in shut-off, disarmed.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= ST_SHUT;
			cnt_r <= DLY_ZERO;
			rel_q_r <= 1'b0;
			armed_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			rel_q_r <= inp.rel;
			armed_r <= (st_r == ST_SHUT) & (armed_r | inp.rel);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs stay closed through the delay and open only in shut-off.
	assign outp.off = (st_r == ST_SHUT);
	assign outp.dly = (st_r == ST_DELAY);
	assign outp.off_ev = (st_r != ST_SHUT) & (st_nxt == ST_SHUT);
	assign outp.rel_ev = (st_r == ST_SHUT) & (st_nxt == ST_RUN);

endmodule

// ===== hw/sto_pkg.sv
// Package for the two-axis safe torque off logic unit.
// Assumes one 200 MHz clock and an APB register port with 32-bit data.
package sto_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock and timing.
	localparam int unsigned CLK_KHZ = 200_000;
	// Input filter time in microseconds.
	localparam int unsigned DEB_US = 1000;
	localparam int unsigned DEB_CYC = DEB_US * (CLK_KHZ / 1000);
	localparam int unsigned DEB_W = 18;
	// Selectable shut-off delays in milliseconds.
	localparam longint unsigned T1_MS = 1400;
	localparam longint unsigned T2_MS = 2800;
	localparam longint unsigned T3_MS = 5600;
	localparam longint unsigned T4_MS = 9800;
	localparam longint unsigned T5_MS = 30800;
	// Bound on the zero-delay response, in milliseconds.
	localparam longint unsigned RESP_MS = 10;
	localparam int unsigned DW = 33;
	localparam logic [DW-1:0] DLY1_CYC = DW'(T1_MS * CLK_KHZ);
	localparam logic [DW-1:0] DLY2_CYC = DW'(T2_MS * CLK_KHZ);
	localparam logic [DW-1:0] DLY3_CYC = DW'(T3_MS * CLK_KHZ);
	localparam logic [DW-1:0] DLY4_CYC = DW'(T4_MS * CLK_KHZ);
	localparam logic [DW-1:0] DLY5_CYC = DW'(T5_MS * CLK_KHZ);
	localparam logic [DW-1:0] DLY_ZERO = '0;

	////////////////////////////////////////////////////////////////////////
	// Delay switch layout: each switch carries one code per axis.
	localparam int unsigned SW_W = 6;
	localparam int unsigned SWA_LSB = 0;
	localparam int unsigned SWB_LSB = 3;
	localparam logic [2:0] DC_0 = 3'h0;
	localparam logic [2:0] DC_1 = 3'h1;
	localparam logic [2:0] DC_2 = 3'h2;
	localparam logic [2:0] DC_3 = 3'h3;
	localparam logic [2:0] DC_4 = 3'h4;
	localparam logic [2:0] DC_5 = 3'h5;

	////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses.
	localparam int unsigned AW = 8;
	localparam logic [AW-1:0] REG_STAT = 8'h00;
	localparam logic [AW-1:0] REG_IRQ = 8'h04;
	localparam logic [AW-1:0] REG_MASK = 8'h08;
	localparam logic [AW-1:0] REG_CTRL = 8'h0c;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;
	// Status bits.
	localparam int unsigned ST_A_OFF = 0;
	localparam int unsigned ST_B_OFF = 1;
	localparam int unsigned ST_A_DLY = 2;
	localparam int unsigned ST_B_DLY = 3;
	localparam int unsigned ST_A_FB = 4;
	localparam int unsigned ST_B_FB = 5;
	localparam int unsigned ST_MATCH = 6;
	localparam int unsigned ST_BADSEL = 7;
	localparam int unsigned ST_W = 8;
	// Event bits of the interrupt status and mask registers.
	localparam int unsigned EV_A_OFF = 0;
	localparam int unsigned EV_B_OFF = 1;
	localparam int unsigned EV_A_REL = 2;
	localparam int unsigned EV_B_REL = 3;
	localparam int unsigned EV_MISM = 4;
	localparam int unsigned EV_W = 5;
	// Control bits.
	localparam int unsigned CT_A_REL = 0;
	localparam int unsigned CT_B_REL = 1;
	localparam int unsigned CT_A_OFF = 2;
	localparam int unsigned CT_B_OFF = 3;
	localparam int unsigned CT_W = 4;

	////////////////////////////////////////////////////////////////////////
	// Types.
	typedef enum logic [1:0] {ST_SHUT, ST_RUN, ST_DELAY} sto_state_t;
	// Filtered inputs of one axis; one means contact closed.
	typedef struct packed {
		logic sw1;
		logic sw2;
		logic rel;
		logic fb;
	} sto_axin_t;
	// State and events of one axis.
	typedef struct packed {
		logic off;
		logic dly;
		logic off_ev;
		logic rel_ev;
	} sto_axout_t;

endpackage

// ===== hw/sto_top.sv
// Two-axis safe torque off logic unit with an APB register port.
// Assumes the APB pins synchronous to pclk; one means a closed contact.
//
// Operation
// - Shut-off state opens both shut-off outputs.
// - Outputs close only while axis is driving.
// - Both redundant outputs always carry one value.
// - Monitor outputs follow the axis shut-off state.
// - Either opened switch input demands shut-off.
// - Axis A releases on connected-then-opened release.
// - Axis B has its own release input.
// - Drive feedback: open shut-off, closed driving.
// - Feedback monitor output mirrors the feedback input.
// - Two switch settings select the shut-off delay.
// - Delay choices per axis; B lacks 5.6 s.
// - Zero delay opens outputs within 10 ms.
// - Report and flag delay switch mismatch.
// - Axes run fully independently; a delay switch mismatch on either axis zeroes the delay of both.
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module sto_top #(
	parameter logic [sto_pkg::DEB_W-1:0] P_DEB_CYC =
		sto_pkg::DEB_W'(sto_pkg::DEB_CYC),
	parameter logic [sto_pkg::DW-1:0] P_DLY1 = sto_pkg::DLY1_CYC,
	parameter logic [sto_pkg::DW-1:0] P_DLY2 = sto_pkg::DLY2_CYC,
	parameter logic [sto_pkg::DW-1:0] P_DLY3 = sto_pkg::DLY3_CYC,
	parameter logic [sto_pkg::DW-1:0] P_DLY4 = sto_pkg::DLY4_CYC,
	parameter logic [sto_pkg::DW-1:0] P_DLY5 = sto_pkg::DLY5_CYC
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sto_pkg::AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt.
	output logic irq,
	// Axis A pins.
	input wire logic axis_a_switch_in_1,
	input wire logic axis_a_switch_in_2,
	input wire logic axis_a_release_in,
	input wire logic axis_a_drive_feedback,
	input wire logic axis_a_drive_feedback_ret,
	output logic axis_a_shutoff_out_1,
	output logic axis_a_shutoff_out_2,
	output logic axis_a_monitor_out_1,
	output logic axis_a_monitor_out_2,
	output logic axis_a_feedback_monitor,
	// Axis B pins.
	input wire logic axis_b_switch_in_1,
	input wire logic axis_b_switch_in_2,
	input wire logic axis_b_release_in,
	input wire logic axis_b_drive_feedback,
	input wire logic axis_b_drive_feedback_ret,
	output logic axis_b_shutoff_out_1,
	output logic axis_b_shutoff_out_2,
	output logic axis_b_monitor_out_1,
	output logic axis_b_monitor_out_2,
	output logic axis_b_feedback_monitor,
	// Delay selection switches.
	input wire logic [sto_pkg::SW_W-1:0] delay_select_switch_1,
	input wire logic [sto_pkg::SW_W-1:0] delay_select_switch_2
);
	import sto_pkg::*;

	localparam int unsigned NF = 10;
	localparam int unsigned NS = NF + 2 * SW_W;

	////////////////////////////////////////////////////////////////////////
	// Delay code decode, shared by both axes: {illegal, cycles}.
	function automatic logic [DW:0] dly_decode(input logic [2:0] code,
			input logic axis_b);
		logic [DW:0] r;
		r = {1'b0, DLY_ZERO};
		unique case (code)
			DC_0: r = {1'b0, DLY_ZERO};
			DC_1: r = {1'b0, P_DLY1};
			DC_2: r = {1'b0, P_DLY2};
			DC_3: r = {axis_b, axis_b ? DLY_ZERO : P_DLY3};
			DC_4: r = {1'b0, P_DLY4};
			DC_5: r = {1'b0, P_DLY5};
			default: r = {1'b1, DLY_ZERO};
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Two-flop synchronisers for every contact and switch pin; the first stage feeds only
	// the second.
	logic [NS-1:0] raw;
	logic [NS-1:0] s1_r;
	logic [NS-1:0] s2_r;

	assign raw = {delay_select_switch_2, delay_select_switch_1,
		axis_b_drive_feedback_ret, axis_b_drive_feedback,
		axis_b_release_in, axis_b_switch_in_2, axis_b_switch_in_1,
		axis_a_drive_feedback_ret, axis_a_drive_feedback,
		axis_a_release_in, axis_a_switch_in_2, axis_a_switch_in_1};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= raw;
			s2_r <= s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Contact filter: a new level is taken only once it has held for the
	// filter time. Reset value reads as all contacts open, so no axis can
	// leave shut-off before the inputs have really been seen.
	logic [NF-1:0] flt_r;
	logic [DEB_W-1:0] deb_r [NF];

	for (genvar i = 0; i < NF; i++) begin : g_deb
		logic diff;
		logic done;
		assign diff = s2_r[i] ^ flt_r[i];
		assign done = (deb_r[i] >= P_DEB_CYC - DEB_W'(1));
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				deb_r[i] <= '0;
				flt_r[i] <= 1'b0;
			end else begin
				deb_r[i] <= (diff && !done) ? deb_r[i] + DEB_W'(1) : '0;
				flt_r[i] <= (diff && done) ? s2_r[i] : flt_r[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Delay switches need no filter: they are set with power off and
	// only compared. A mismatch or a code an axis lacks falls back to
	// zero delay, the safe side.
	logic [SW_W-1:0] sw1;
	logic [SW_W-1:0] sw2;
	logic sw_match;
	logic [DW:0] dec_a;
	logic [DW:0] dec_b;
	logic bad_sel;
	logic [DW-1:0] dly_a;
	logic [DW-1:0] dly_b;

	assign sw1 = s2_r[NF +: SW_W];
	assign sw2 = s2_r[NF + SW_W +: SW_W];
	assign sw_match = (sw1 == sw2);
	assign dec_a = dly_decode(sw1[SWA_LSB +: 3], 1'b0);
	assign dec_b = dly_decode(sw1[SWB_LSB +: 3], 1'b1);
	assign bad_sel = dec_a[DW] | dec_b[DW];
	assign dly_a = (sw_match && !dec_a[DW]) ? dec_a[DW-1:0] : DLY_ZERO;
	assign dly_b = (sw_match && !dec_b[DW]) ? dec_b[DW-1:0] : DLY_ZERO;

	////////////////////////////////////////////////////////////////////////
	// Register state.
	logic [CT_W-1:0] ctrl_r;
	logic [EV_W-1:0] irq_stat_r;
	logic [EV_W-1:0] irq_mask_r;
	logic match_q_r;

	////////////////////////////////////////////////////////////////////////
	// Axis inputs; the software release bit is or-ed with the pin, so the
	// same press-then-let-go sequence applies to both sources.
	sto_axin_t in_a;
	sto_axin_t in_b;
	sto_axout_t out_a;
	sto_axout_t out_b;

	assign in_a.sw1 = flt_r[0];
	assign in_a.sw2 = flt_r[1];
	assign in_a.rel = flt_r[2] | ctrl_r[CT_A_REL];
	assign in_a.fb = flt_r[3] & flt_r[4];
	assign in_b.sw1 = flt_r[5];
	assign in_b.sw2 = flt_r[6];
	assign in_b.rel = flt_r[7] | ctrl_r[CT_B_REL];
	assign in_b.fb = flt_r[8] & flt_r[9];

	// Each axis owns its inputs and its delay code; the switch match covers both codes, so either mismatch zeroes both delays.
	sto_axis u_axis_a (
		.pclk(pclk),
		.presetn(presetn),
		.inp(in_a),
		.force_off(ctrl_r[CT_A_OFF]),
		.dly_cyc(dly_a),
		.outp(out_a)
	);

	sto_axis u_axis_b (
		.pclk(pclk),
		.presetn(presetn),
		.inp(in_b),
		.force_off(ctrl_r[CT_B_OFF]),
		.dly_cyc(dly_b),
		.outp(out_b)
	);

	////////////////////////////////////////////////////////////////////////
	// Pin outputs, one flop per axis feeding both redundant contacts so the
	// pair can never disagree.
	logic clo_a_r;
	logic clo_b_r;
	logic fbm_a_r;
	logic fbm_b_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clo_a_r <= 1'b0;
			clo_b_r <= 1'b0;
			fbm_a_r <= 1'b0;
			fbm_b_r <= 1'b0;
		end else begin
			clo_a_r <= ~out_a.off;
			clo_b_r <= ~out_b.off;
			fbm_a_r <= in_a.fb;
			fbm_b_r <= in_b.fb;
		end
	end

	assign axis_a_shutoff_out_1 = clo_a_r;
	assign axis_a_shutoff_out_2 = clo_a_r;
	assign axis_a_monitor_out_1 = clo_a_r;
	assign axis_a_monitor_out_2 = clo_a_r;
	assign axis_b_shutoff_out_1 = clo_b_r;
	assign axis_b_shutoff_out_2 = clo_b_r;
	assign axis_b_monitor_out_1 = clo_b_r;
	assign axis_b_monitor_out_2 = clo_b_r;
	assign axis_a_feedback_monitor = fbm_a_r;
	assign axis_b_feedback_monitor = fbm_b_r;

	////////////////////////////////////////////////////////////////////////
	// APB decode. Every access gets one wait-free access cycle: the answer
	// is prepared in the setup cycle and registered.
	logic setup;
	logic wr_en;
	logic hit_stat;
	logic hit_irq;
	logic hit_mask;
	logic hit_ctrl;
	logic mapped;
	logic [31:0] status_w;
	logic [31:0] rd_mux;

	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pwrite & pready & ~pslverr;
	assign hit_stat = (paddr == REG_STAT);
	assign hit_irq = (paddr == REG_IRQ);
	assign hit_mask = (paddr == REG_MASK);
	assign hit_ctrl = (paddr == REG_CTRL);
	assign mapped = hit_stat | hit_irq | hit_mask | hit_ctrl;

	// Live status word.
	always_comb begin
		status_w = RD_ZERO;
		status_w[ST_A_OFF] = out_a.off;
		status_w[ST_B_OFF] = out_b.off;
		status_w[ST_A_DLY] = out_a.dly;
		status_w[ST_B_DLY] = out_b.dly;
		status_w[ST_A_FB] = in_a.fb;
		status_w[ST_B_FB] = in_b.fb;
		status_w[ST_MATCH] = sw_match;
		status_w[ST_BADSEL] = bad_sel;
	end

	assign rd_mux = hit_stat ? status_w :
		hit_irq ? {{(32 - EV_W){1'b0}}, irq_stat_r} :
		hit_mask ? {{(32 - EV_W){1'b0}}, irq_mask_r} :
		hit_ctrl ? {{(32 - CT_W){1'b0}}, ctrl_r} : RD_ZERO;

	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= RD_ZERO;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			prdata_r <= (setup && !pwrite) ? rd_mux : RD_ZERO;
			pready_r <= setup;
			pslverr_r <= setup & ~mapped;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;

	////////////////////////////////////////////////////////////////////////
	// Events and writable registers. A new event wins over a write-one
	// clear in the same cycle, so nothing is lost.
	logic [EV_W-1:0] ev;
	logic [EV_W-1:0] w1c;
	logic [EV_W-1:0] irq_stat_nxt;
	logic irq_r;

	assign ev = {match_q_r & ~sw_match, out_b.rel_ev, out_a.rel_ev,
		out_b.off_ev, out_a.off_ev};
	assign w1c = (wr_en && hit_irq) ? pwdata[EV_W-1:0] : '0;
	assign irq_stat_nxt = (irq_stat_r & ~w1c) | ev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= '0;
			irq_mask_r <= '0;
			irq_stat_r <= '0;
			match_q_r <= 1'b1;
			irq_r <= 1'b0;
		end else begin
			ctrl_r <= (wr_en && hit_ctrl) ? pwdata[CT_W-1:0] : ctrl_r;
			irq_mask_r <= (wr_en && hit_mask) ? pwdata[EV_W-1:0] : irq_mask_r;
			irq_stat_r <= irq_stat_nxt;
			match_q_r <= sw_match;
			irq_r <= |(irq_stat_nxt & irq_mask_r);
		end
	end

	assign irq = irq_r;

endmodule
